// ### logic/eeenp_regs.sv
// Purpose: EEE next-page transmit register slice behind indirect access
// Assumes: Software drives select, offset and data byte strobes on i_sys_clk
// Notes:   Only ports 3 and 4 of the EEE table respond; others read zero
//
// Behaviour
// RULE1 - Expansion bit 0 is read-only, shows partner auto-negotiation ability, resets 0.
// RULE2 - Software selects table 001 in select bits 7:5 and port 3 or 4 in bits 3:0.
// RULE3 - Software writes the byte offset; the addressed byte is read or written via data.
// RULE4 - Transmit word upper byte sits at offset 0x0E and lower byte at 0x0F.
// RULE5 - Bit 15 more-pages flag is read/write and resets 0.
// RULE6 - Bit 13 message page select is read/write and resets 1.
// RULE7 - Bit 11 toggle is read-only, resets 0, and inverts the last exchanged toggle.
// RULE8 - The first next page toggle is the inverse of base codeword bit 11.
// RULE9 - Bits 10:0 code field is read/write and resets to 1.
// RULE10 - Software programs the word only while EEE port register 5 bit 7 is set; the slice does not check it and accepts writes at any time.
// RULE11 - Bit 14 reads 0, bit 12 is read/write resetting 0, read-only writes ignored.
`timescale 1ns/100ps
module eeenp_regs
    import eeenp_pkg::*;
#(
    parameter int NUM_PORTS = EEENP_NUM_PORTS   // Ports served
)(
    input  wire logic                 i_sys_clk,    // Core clock 250 MHz
    input  wire logic                 i_reset,      // Sync reset, high
    input  wire logic                 i_sel_wr,     // Write indirect select
    input  wire logic [7:0]           i_sel_data,   // Select byte
    input  wire logic                 i_ofs_wr,     // Write indirect offset
    input  wire logic [7:0]           i_ofs_data,   // Offset byte
    input  wire logic                 i_data_wr,    // Write data byte
    input  wire logic [7:0]           i_data_wdata, // Data byte in
    input  wire eeenp_an_t            i_an [NUM_PORTS], // Engine events
    output logic      [7:0]           o_data_rdata, // Data byte out
    output logic      [7:0]           o_sel,        // Select readback
    output logic      [7:0]           o_ofs,        // Offset readback
    output logic      [15:0]          o_np_word [NUM_PORTS], // Words to engine
    output eeenp_np_t                 o_np [NUM_PORTS]       // Writable fields
);

    // ---------------------------------------------------------------
    // Indirect select and offset
    // ---------------------------------------------------------------
    logic [7:0] sel;
    logic [7:0] ofs;
    logic [7:0] next_sel;
    logic [7:0] next_ofs;

    // RULE2 RULE3 hold until rewritten
    assign next_sel = i_sel_wr ? i_sel_data : sel;
    assign next_ofs = i_ofs_wr ? i_ofs_data : ofs;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sel <= EEENP_RST_BYTE;
            ofs <= EEENP_RST_BYTE;
        end else begin
            sel <= next_sel;
            ofs <= next_ofs;
        end
    end

    // ---------------------------------------------------------------
    // Select decode
    // ---------------------------------------------------------------
    wire [2:0] sel_table    = sel[EEENP_SEL_TABLE_HI:EEENP_SEL_TABLE_LO];
    wire [3:0] sel_port     = sel[EEENP_SEL_PORT_HI:EEENP_SEL_PORT_LO];
    // RULE2 only the EEE table
    wire       table_ok     = (sel_table == EEENP_TABLE_EEE);
    // RULE2 only ports 3 and 4
    wire       port_low_ok  = (sel_port >= EEENP_PORT_FIRST);
    wire       port_high_ok = (sel_port <= EEENP_PORT_LAST);
    wire       port_ok      = table_ok && port_low_ok && port_high_ok;
    // Wraps for low ports, harmless since port_ok is then low
    wire [3:0] port_rel     = sel_port - EEENP_PORT_FIRST;

    // ---------------------------------------------------------------
    // Offset decode
    // ---------------------------------------------------------------
    // RULE1 RULE4 byte offsets of the word and expansion low byte
    wire       ofs_np_hi    = (ofs == EEENP_OFS_NP_HI);
    wire       ofs_np_lo    = (ofs == EEENP_OFS_NP_LO);
    wire       ofs_ex_lo    = (ofs == EEENP_OFS_EXP_LO);

    // ---------------------------------------------------------------
    // Ports
    // ---------------------------------------------------------------
    wire  [7:0] rd_part  [NUM_PORTS];
    wire  [7:0] rd_chain [NUM_PORTS + 1];
    logic [7:0] exp_lo   [NUM_PORTS];

    // Unselected ports add zero to the readback OR
    assign rd_chain[0] = EEENP_RST_BYTE;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            wire       hit        = port_ok && (port_rel == 4'(g));
            // RULE3 data byte writes the addressed byte
            wire       wr_hi      = i_data_wr && hit && ofs_np_hi;
            wire       wr_lo      = i_data_wr && hit && ofs_np_lo;
            wire [7:0] byte_np_hi = o_np_word[g][15:8];
            wire [7:0] byte_np_lo = o_np_word[g][7:0];
            // RULE1 RULE4 byte select, others read zero
            wire [7:0] byte_sel   = ofs_np_hi ? byte_np_hi
                                  : ofs_np_lo ? byte_np_lo
                                  : ofs_ex_lo ? exp_lo[g]
                                  : EEENP_RST_BYTE;

            assign rd_part[g]      = hit ? byte_sel : EEENP_RST_BYTE;
            assign rd_chain[g + 1] = rd_chain[g] | rd_part[g];

            eeenp_port u_port (
                .i_sys_clk (i_sys_clk),
                .i_reset   (i_reset),
                .i_wr_hi   (wr_hi),
                .i_wr_lo   (wr_lo),
                .i_wdata   (i_data_wdata),
                .i_an      (i_an[g]),
                .o_exp_lo  (exp_lo[g]),
                .o_np_word (o_np_word[g]),
                .o_np      (o_np[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    wire [7:0] next_rdata = rd_chain[NUM_PORTS];

    // Registered so a read is stable one cycle after offset changes
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_data_rdata <= EEENP_RST_BYTE;
        end else begin
            o_data_rdata <= next_rdata;
        end
    end

    assign o_sel = sel;
    assign o_ofs = ofs;

endmodule : eeenp_regs

// ### logic/eeenp_pkg.sv
// Purpose: Constants and types for the EEE next-page transmit register slice
// Assumes: Byte-wide indirect access through select, offset and data registers
// Notes:   Shared by the slice top and its per-port holder
package eeenp_pkg;

    // ---------------------------------------------------------------
    // Indirect access
    // ---------------------------------------------------------------
    localparam logic [2:0] EEENP_TABLE_EEE     = 3'h1;
    localparam int         EEENP_SEL_TABLE_HI  = 7;
    localparam int         EEENP_SEL_TABLE_LO  = 5;
    localparam int         EEENP_SEL_PORT_HI   = 3;
    localparam int         EEENP_SEL_PORT_LO   = 0;
    localparam logic [3:0] EEENP_PORT_FIRST    = 4'h3;
    localparam logic [3:0] EEENP_PORT_LAST     = 4'h4;
    localparam int         EEENP_NUM_PORTS     = 2;

    // ---------------------------------------------------------------
    // Offsets within a port
    // ---------------------------------------------------------------
    localparam logic [7:0] EEENP_OFS_EXP_HI    = 8'h0C;
    localparam logic [7:0] EEENP_OFS_EXP_LO    = 8'h0D;
    localparam logic [7:0] EEENP_OFS_NP_HI     = 8'h0E;
    localparam logic [7:0] EEENP_OFS_NP_LO     = 8'h0F;

    // ---------------------------------------------------------------
    // Next-page transmit word fields
    // ---------------------------------------------------------------
    localparam int EEENP_BIT_MORE     = 15;
    localparam int EEENP_BIT_RSVD     = 14;
    localparam int EEENP_BIT_MSG      = 13;
    localparam int EEENP_BIT_ACK2     = 12;
    localparam int EEENP_BIT_TOGGLE   = 11;
    localparam int EEENP_CODE_W       = 11;
    localparam int EEENP_BIT_LP_AN    = 0;

    localparam logic        EEENP_RST_MORE   = 1'b0;
    localparam logic        EEENP_RST_MSG    = 1'b1;
    localparam logic        EEENP_RST_ACK2   = 1'b0;
    localparam logic        EEENP_RST_TOGGLE = 1'b0;
    localparam logic [10:0] EEENP_RST_CODE   = 11'h001;
    localparam logic [7:0]  EEENP_RST_BYTE   = 8'h00;
    localparam int          EEENP_BYTE_W     = 8;

    // Writable fields of the transmit word
    typedef struct packed {
        logic        more_pages_flag;
        logic        message_page_select;
        logic        ack2;
        logic [10:0] code;
    } eeenp_np_t;

    // Events from the negotiation engine for one port
    typedef struct packed {
        logic lp_an_able;
        logic base_sent;
        logic base_toggle;
        logic page_sent;
    } eeenp_an_t;

endpackage : eeenp_pkg

// ### logic/eeenp_port.sv
// Purpose: One port's next-page transmit word and link partner status
// Assumes: Engine events are synchronous to i_sys_clk
// Notes:   Instantiated once per indirectly addressed port
`timescale 1ns/100ps
module eeenp_port
    import eeenp_pkg::*;
(
    input  wire logic       i_sys_clk,   // Core clock
    input  wire logic       i_reset,     // Sync reset, high
    input  wire logic       i_wr_hi,     // Write upper byte
    input  wire logic       i_wr_lo,     // Write lower byte
    input  wire logic [7:0] i_wdata,     // Write byte
    input  wire eeenp_an_t  i_an,        // Engine events
    output logic      [7:0] o_exp_lo,    // Expansion low byte
    output logic      [15:0] o_np_word,  // Transmit word
    output eeenp_np_t       o_np         // Writable fields
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    eeenp_np_t np;
    logic      toggle;
    logic      lp_an;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            // RULE5 RULE6 RULE9 reset values
            np.more_pages_flag     <= EEENP_RST_MORE;
            np.message_page_select <= EEENP_RST_MSG;
            np.ack2                <= EEENP_RST_ACK2;
            np.code                <= EEENP_RST_CODE;
        end else begin
            // RULE5 RULE6 writable upper bits
            if (i_wr_hi) begin
                np.more_pages_flag     <= i_wdata[EEENP_BIT_MORE - EEENP_BYTE_W];
                np.message_page_select <= i_wdata[EEENP_BIT_MSG - EEENP_BYTE_W];
                // RULE11 second acknowledge
                np.ack2                <= i_wdata[EEENP_BIT_ACK2 - EEENP_BYTE_W];
                np.code[EEENP_CODE_W-1:EEENP_BYTE_W]
                    <= i_wdata[EEENP_CODE_W-EEENP_BYTE_W-1:0];
            end
            // RULE9 code field low byte
            if (i_wr_lo) begin
                np.code[EEENP_BYTE_W-1:0] <= i_wdata;
            end
        end
    end

    // RULE8 first page from base word
    // RULE7 invert after each exchange
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            toggle <= EEENP_RST_TOGGLE;
        end else if (i_an.base_sent) begin
            toggle <= ~i_an.base_toggle;
        end else if (i_an.page_sent) begin
            toggle <= ~toggle;
        end
    end

    // RULE1 partner capability, reset 0
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            lp_an <= 1'b0;
        end else begin
            lp_an <= i_an.lp_an_able;
        end
    end

    // RULE11 reserved bit reads zero
    assign o_np_word = {np.more_pages_flag, 1'b0, np.message_page_select,
                        np.ack2, toggle, np.code};
    assign o_exp_lo  = {7'h00, lp_an};
    assign o_np      = np;

endmodule : eeenp_port

// ### verification/eeenp_regs_asserts.sv
// Purpose: Port-level checks of the EEE next-page slice
// Assumes: Index 0 is port 3; select 0x23 reaches it
// Notes:   Bound into eeenp_regs
`timescale 1ns/100ps
module eeenp_regs_chk
    import eeenp_pkg::*;
#(
    parameter int NUM_PORTS = EEENP_NUM_PORTS   // Ports served
)(
    input wire logic        i_sys_clk,              // Core clock
    input wire logic        i_reset,                // Sync reset
    input wire logic        i_data_wr,              // Data strobe
    input wire logic [7:0]  i_data_wdata,           // Data byte
    input wire eeenp_an_t   i_an [NUM_PORTS],       // Engine events
    input wire logic [7:0]  o_data_rdata,           // Read byte
    input wire logic [7:0]  o_sel,                  // Select
    input wire logic [7:0]  o_ofs,                  // Offset
    input wire logic [15:0] o_np_word [NUM_PORTS],  // Words
    input wire eeenp_np_t   o_np [NUM_PORTS]        // Fields
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_hi; i_data_wr && o_sel == 8'h23 && o_ofs == EEENP_OFS_NP_HI; endsequence
    sequence s_lo; i_data_wr && o_sel == 8'h23 && o_ofs == EEENP_OFS_NP_LO; endsequence
    property p_rst; $fell(i_reset) |-> o_np_word[0] == 16'h2001 && o_sel == 8'h00; endproperty
    property p_hi; s_hi |=> (o_np_word[0][15:8] & 8'hB0) == ($past(i_data_wdata) & 8'hB0);
    endproperty
    property p_lo; s_lo |=> o_np_word[0][7:0] == $past(i_data_wdata); endproperty
    property p_rsvd; o_np_word[0][14] == 1'b0 && o_np_word[1][14] == 1'b0; endproperty
    property p_base; i_an[0].base_sent |=> o_np_word[0][11] != $past(i_an[0].base_toggle);
    endproperty
    property p_page; i_an[0].page_sent && !i_an[0].base_sent
        |=> o_np_word[0][11] != $past(o_np_word[0][11]); endproperty
    property p_hold; !i_an[0].page_sent && !i_an[0].base_sent |=> $stable(o_np_word[0][11]);
    endproperty
    property p_ref; i_data_wr && o_sel[7:5] != EEENP_TABLE_EEE
        |=> $stable(o_np[0]) && $stable(o_np[1]); endproperty
    property p_rd; o_sel == 8'h23 && o_ofs == EEENP_OFS_NP_LO
        |=> o_data_rdata == $past(o_np_word[0][7:0]); endproperty
    a_rst: assert property (p_rst) else $error("reset word wrong");
    a_hi: assert property (p_hi) else $error("upper byte write wrong");
    a_lo: assert property (p_lo) else $error("lower byte write wrong");
    a_rsvd: assert property (p_rsvd) else $error("bit 14 set");
    a_base: assert property (p_base) else $error("first toggle wrong");
    a_page: assert property (p_page) else $error("toggle not inverted");
    a_hold: assert property (p_hold) else $error("toggle moved");
    a_ref: assert property (p_ref) else $error("foreign table wrote");
    a_rd: assert property (p_rd) else $error("read byte wrong");
endmodule : eeenp_regs_chk
bind eeenp_regs eeenp_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.i_sys_clk, .i_reset,
    .i_data_wr, .i_data_wdata, .i_an, .o_data_rdata, .o_sel, .o_ofs, .o_np_word, .o_np);

// ### verification/eeenp_regs_tb_top.sv
// Purpose: Directed bench for the EEE next-page slice
// Assumes: Read byte lands one edge after the offset
// Notes:   Port 3 is index 0, port 4 index 1
`timescale 1ns/100ps
module eeenp_regs_tb_top
    import eeenp_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, sw = 1'b0, ow = 1'b0, dw = 1'b0;
    logic [7:0]  sd = 8'h00, od = 8'h00, dd = 8'h00, rdata, sel_rb, ofs_rb;
    logic [15:0] word [2];
    eeenp_an_t   an [2] = '{default: '0};
    eeenp_np_t   np [2];
    int          n_compared = 0, fail_count = 0;
    always #2 clk = ~clk;
    eeenp_regs u_dut (.i_sys_clk(clk), .i_reset(rst), .i_sel_wr(sw), .i_sel_data(sd),
        .i_ofs_wr(ow), .i_ofs_data(od), .i_data_wr(dw), .i_data_wdata(dd), .i_an(an),
        .o_data_rdata(rdata), .o_sel(sel_rb), .o_ofs(ofs_rb), .o_np_word(word), .o_np(np));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One strobe: 0 select, 1 offset, 2 data
    task automatic put(input int k, input logic [7:0] v);
        @(posedge clk);
        case (k)
            0: begin sw <= 1'b1; sd <= v; end
            1: begin ow <= 1'b1; od <= v; end
            default: begin dw <= 1'b1; dd <= v; end
        endcase
        @(posedge clk);
        {sw, ow, dw} <= 3'b000;
    endtask : put
    task automatic rd(input logic [7:0] s, input logic [7:0] o, input logic [7:0] e);
        put(0, s);
        put(1, o);
        repeat (2) @(posedge clk);
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask : rd
    // Engine event on port 3: b selects base page, else next page
    task automatic ev(input logic b, input logic t, input logic e);
        @(posedge clk);
        an[0].base_sent <= b;
        an[0].page_sent <= !b;
        an[0].base_toggle <= t;
        @(posedge clk);
        {an[0].base_sent, an[0].page_sent} <= 2'b00;
        @(posedge clk);
        #1 chk({15'h0000, word[0][11]}, {15'h0000, e});
    endtask : ev
    task automatic t_reset;
        rd(8'h23, 8'h0E, 8'h20);
        rd(8'h24, 8'h0F, 8'h01);
        rd(8'h23, 8'h0D, 8'h00);
        chk(word[1], 16'h2001);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_write;
        put(0, 8'h23);
        put(1, 8'h0E);
        put(2, 8'hFF);
        rd(8'h23, 8'h0E, 8'hB7);
        put(2, 8'hFF);
        rd(8'h23, 8'h0F, 8'h01);
        put(2, 8'h5A);
        rd(8'h23, 8'h0F, 8'h5A);
        chk(word[0], 16'hB75A);
        chk(word[1], 16'h2001);
        chk({2'b00, np[0]}, {5'b00111, 11'h75A});
        chk({8'h00, sel_rb}, 16'h0023);
        chk({8'h00, ofs_rb}, 16'h000F);
        $display("t_write done");
    endtask : t_write
    task automatic t_refuse;
        put(0, 8'h43);
        put(1, 8'h0E);
        put(2, 8'h00);
        #1 chk(word[0], 16'hB75A);
        rd(8'h25, 8'h0F, 8'h00);
        put(0, 8'h23);
        put(1, 8'h10);
        put(2, 8'h00);
        #1 chk(word[0], 16'hB75A);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_toggle;
        ev(1'b1, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b0, 1'b1);
        rd(8'h23, 8'h0E, 8'hBF);
        put(2, 8'h00);
        #1 chk(word[0], 16'h085A);
        $display("t_toggle done");
    endtask : t_toggle
    task automatic t_lp;
        an[1].lp_an_able <= 1'b1;
        rd(8'h24, 8'h0D, 8'h01);
        rd(8'h24, 8'h0C, 8'h00);
        rd(8'h23, 8'h0D, 8'h00);
        $display("t_lp done");
    endtask : t_lp
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_refuse();
        t_toggle();
        t_lp();
        stop_test();
    end
    // Whole run needs about 125 cycles
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
endmodule : eeenp_regs_tb_top
